/* hdl/gslp_pins.sv */
// gpio pins with status lamp function and crossover strap sampling
`timescale 1ns/10ps
`default_nettype none
`include "gslp_defines.svh"

module gslp_pins #(
    parameter int unsigned BLINK_TICKS = `GSLP_BLINK_TICKS
) (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_b_i,
    input  wire gslp_pkg::gslp_dir_t [2:0] pin_dir_i,
    input  wire logic [2:0]                pin_out_data_i,
    input  wire logic [2:0]                pin_lamp_mode_i,
    input  wire gslp_pkg::gslp_phy_status_s phy_status_i,
    input  wire logic [2:0]                pin_i,
    input  wire logic                      auto_crossover_strap_i,
    input  wire logic                      crossover_pair_swap_i,
    output logic [2:0]                     pin_o,
    output logic [2:0]                     pin_oe_o,
    output logic [2:0]                     pin_in_data_o,
    output logic                           auto_crossover_en_o,
    output logic                           line_pairs_swapped_o,
    output logic                           ref_tick_o
);
    localparam int unsigned DIV = `GSLP_REF_DIV;

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] pin_in_reg;
    logic       strap_meta_reg;
    logic       strap_sync_reg;
    logic       xover_reg;
    logic       strap_seen_reg;
    logic       swap_reg;
    logic       xover_next;
    logic       strap_seen_next;
    logic       swap_next;
    logic [1:0] strap_wait_reg;
    logic [1:0] strap_wait_next;

    logic [3:0]  div_reg;
    logic [3:0]  div_next;
    logic        tick_reg;
    logic        tick_next;
    logic [31:0] blink_cnt_reg;
    logic [31:0] blink_cnt_next;
    gslp_pkg::gslp_blink_e blink_reg;
    gslp_pkg::gslp_blink_e blink_next;

    gslp_pkg::gslp_phy_status_s stat_reg;
    gslp_pkg::gslp_pin_drive_s  drv_reg;
    gslp_pkg::gslp_pin_drive_s  drv_next;
    logic [2:0] lamp_n;

    // pins and strap come from the board, so two flops first
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pin_meta_reg   <= 3'h0;
            pin_sync_reg   <= 3'h0;
            pin_in_reg     <= 3'h0;
            strap_meta_reg <= 1'h1;
            strap_sync_reg <= 1'h1;
            stat_reg       <= '0;
        end else begin
            pin_meta_reg   <= pin_i;
            pin_sync_reg   <= pin_meta_reg;
            pin_in_reg     <= pin_sync_reg;
            strap_meta_reg <= auto_crossover_strap_i;
            strap_sync_reg <= strap_meta_reg;
            stat_reg       <= phy_status_i;
        end
    end

    // strap is caught once, only after the synchroniser has refilled past its reset value
    // later strap changes are ignored until the next reset
    always_comb begin
        xover_next      = xover_reg;
        strap_seen_next = strap_seen_reg;
        strap_wait_next = strap_wait_reg;
        if (!strap_seen_reg) begin
            if (strap_wait_reg == `GSLP_STRAP_SETTLE) begin
                xover_next      = strap_sync_reg;
                strap_seen_next = 1'b1;
            end else begin
                strap_wait_next = strap_wait_reg + 2'h1;
            end
        end
        swap_next = xover_reg & crossover_pair_swap_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            xover_reg      <= 1'h1;
            strap_seen_reg <= 1'h0;
            strap_wait_reg <= 2'h0;
            swap_reg       <= 1'h0;
        end else begin
            xover_reg      <= xover_next;
            strap_seen_reg <= strap_seen_next;
            strap_wait_reg <= strap_wait_next;
            swap_reg       <= swap_next;
        end
    end

    // 25 MHz reference tick, blink counted in reference ticks
    always_comb begin
        div_next  = div_reg + 4'h1;
        tick_next = 1'b0;
        if (div_reg == 4'(DIV - 1)) begin
            div_next  = 4'h0;
            tick_next = 1'b1;
        end
        blink_next     = blink_reg;
        blink_cnt_next = blink_cnt_reg;
        if (!stat_reg.link_up) begin
            blink_next     = gslp_pkg::GSLP_BLINK_IDLE;
            blink_cnt_next = 32'h0;
        end else if (tick_reg) begin
            unique case (blink_reg)
                gslp_pkg::GSLP_BLINK_IDLE: begin
                    if (stat_reg.activity) begin
                        blink_next     = gslp_pkg::GSLP_BLINK_OFF;
                        blink_cnt_next = 32'h0;
                    end
                end
                gslp_pkg::GSLP_BLINK_OFF: begin
                    blink_cnt_next = blink_cnt_reg + 32'h1;
                    if (blink_cnt_reg == BLINK_TICKS - 1) begin
                        blink_next     = gslp_pkg::GSLP_BLINK_ON;
                        blink_cnt_next = 32'h0;
                    end
                end
                gslp_pkg::GSLP_BLINK_ON: begin
                    blink_cnt_next = blink_cnt_reg + 32'h1;
                    if (blink_cnt_reg == BLINK_TICKS - 1) begin
                        blink_next     = gslp_pkg::GSLP_BLINK_IDLE;
                        blink_cnt_next = 32'h0;
                    end
                end
                default: begin
                    blink_next     = gslp_pkg::GSLP_BLINK_IDLE;
                    blink_cnt_next = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            div_reg       <= 4'h0;
            tick_reg      <= 1'h0;
            blink_reg     <= gslp_pkg::GSLP_BLINK_IDLE;
            blink_cnt_reg <= 32'h0;
        end else begin
            div_reg       <= div_next;
            tick_reg      <= tick_next;
            blink_reg     <= blink_next;
            blink_cnt_reg <= blink_cnt_next;
        end
    end

    // lamp levels, active low
    always_comb begin
        // speed pin floats high only on a settled 10 Mb/s link
        lamp_n[`GSLP_PIN_SPEED]  = stat_reg.speed_10 & stat_reg.link_up
                                   & ~stat_reg.negotiating;
        lamp_n[`GSLP_PIN_LINK]   = ~stat_reg.link_up
                                   | (blink_reg == gslp_pkg::GSLP_BLINK_OFF);
        lamp_n[`GSLP_PIN_DUPLEX] = ~(stat_reg.full_duplex & stat_reg.link_up);
    end

    // pin drive per pin; lamp mode wins over gpio direction
    generate
        for (genvar p = 0; p < `GSLP_NUM_PINS; p++) begin : g_pin
            always_comb begin
                drv_next.o[p]  = 1'b0;
                drv_next.oe[p] = 1'b0;
                if (pin_lamp_mode_i[p]) begin
                    // open drain: pull low only, release for high
                    drv_next.oe[p] = ~lamp_n[p];
                end else begin
                    unique case (pin_dir_i[p])
                        `GSLP_DIR_PUSH_PULL: begin
                            drv_next.o[p]  = pin_out_data_i[p];
                            drv_next.oe[p] = 1'b1;
                        end
                        `GSLP_DIR_OPEN_DRAIN: begin
                            drv_next.oe[p] = ~pin_out_data_i[p];
                        end
                        default: begin
                            drv_next.oe[p] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign pin_o                = drv_reg.o;
    assign pin_oe_o             = drv_reg.oe;
    assign pin_in_data_o        = pin_in_reg;
    assign auto_crossover_en_o  = xover_reg;
    assign line_pairs_swapped_o = swap_reg;
    assign ref_tick_o           = tick_reg;
endmodule
`default_nettype wire

/* hdl/gslp_defines.svh */
// constants for the gpio and status lamp pin block
`ifndef GSLP_DEFINES_SVH
`define GSLP_DEFINES_SVH

`define GSLP_NUM_PINS       3
`define GSLP_PIN_SPEED      0
`define GSLP_PIN_LINK       1
`define GSLP_PIN_DUPLEX     2
`define GSLP_SYS_CLK_MHZ    250
`define GSLP_REF_CLK_MHZ    25
`define GSLP_REF_DIV        (`GSLP_SYS_CLK_MHZ / `GSLP_REF_CLK_MHZ)
`define GSLP_BLINK_MS       80
`define GSLP_BLINK_TICKS    (`GSLP_BLINK_MS * 1000 * `GSLP_REF_CLK_MHZ)
`define GSLP_STRAP_SETTLE   2'h2
`define GSLP_DIR_INPUT      2'h0
`define GSLP_DIR_PUSH_PULL  2'h1
`define GSLP_DIR_OPEN_DRAIN 2'h2

`endif

/* hdl/gslp_pkg.sv */
// types for the gpio and status lamp pin block
`default_nettype none
package gslp_pkg;
    typedef logic [1:0] gslp_dir_t;

    typedef struct packed {
        logic speed_10;
        logic negotiating;
        logic link_up;
        logic full_duplex;
        logic activity;
    } gslp_phy_status_s;

    typedef struct packed {
        logic [2:0] o;
        logic [2:0] oe;
    } gslp_pin_drive_s;

    typedef enum logic [2:0] {
        GSLP_BLINK_IDLE = 3'h1,
        GSLP_BLINK_OFF  = 3'h2,
        GSLP_BLINK_ON   = 3'h4
    } gslp_blink_e;
endpackage
`default_nettype wire

/* sim/gslp_pins_props.sv */
// assertions for the gpio and status lamp pin block
`timescale 1ns/10ps
`default_nettype none
`include "gslp_defines.svh"
module gslp_pins_props #(parameter int unsigned BLINK_TICKS = 5) (
    input wire logic                       sys_clk_i,
    input wire logic                       rst_b_i,
    input wire gslp_pkg::gslp_dir_t [2:0]  pin_dir_i,
    input wire logic [2:0]                 pin_out_data_i,
    input wire logic [2:0]                 pin_lamp_mode_i,
    input wire gslp_pkg::gslp_phy_status_s phy_status_i,
    input wire logic                       crossover_pair_swap_i,
    input wire logic [2:0]                 pin_o,
    input wire logic [2:0]                 pin_oe_o,
    input wire logic                       auto_crossover_en_o,
    input wire logic                       line_pairs_swapped_o,
    input wire logic                       ref_tick_o
);
    gslp_pkg::gslp_phy_status_s st1_reg, st2_reg, st3_reg;
    gslp_pkg::gslp_dir_t [2:0]  dir1_reg;
    logic [2:0]                 dat1_reg, mode1_reg;
    int unsigned                off_reg, off_next;
    // link loss, gpio use or reset clears the count, so only blink gaps are timed
    always_comb off_next = (pin_oe_o[1] || !rst_b_i || !st2_reg.link_up || !mode1_reg[1])
                           ? '0 : off_reg + 1;
    always_ff @(posedge sys_clk_i) begin
        st1_reg   <= phy_status_i;
        st2_reg   <= st1_reg;
        st3_reg   <= st2_reg;
        dir1_reg  <= pin_dir_i;
        dat1_reg  <= pin_out_data_i;
        mode1_reg <= pin_lamp_mode_i;
        off_reg   <= off_next;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_tick_spacing: assert property (
        ref_tick_o |=> !ref_tick_o [*8] ##1 !ref_tick_o ##1 ref_tick_o) else $error("tick");
    chk_speed_lamp: assert property (
        mode1_reg[0] |-> !pin_o[0]
        && pin_oe_o[0] == !(st2_reg.link_up && st2_reg.speed_10 && !st2_reg.negotiating))
        else $error("speed lamp");
    chk_duplex_lamp: assert property (
        mode1_reg[2] |-> !pin_o[2] && pin_oe_o[2] == (st2_reg.full_duplex && st2_reg.link_up))
        else $error("duplex lamp");
    chk_link_release: assert property (
        mode1_reg[1] && !st2_reg.link_up && !st3_reg.link_up |-> !pin_o[1] && !pin_oe_o[1])
        else $error("link lamp");
    for (genvar k = 0; k < 3; k++) begin : g_pin
        chk_gpio_drive: assert property (
            !mode1_reg[k] |-> pin_oe_o[k] == (dir1_reg[k] == `GSLP_DIR_PUSH_PULL
            || (dir1_reg[k] == `GSLP_DIR_OPEN_DRAIN && !dat1_reg[k]))
            && (!pin_oe_o[k] || pin_o[k] == (dir1_reg[k] == `GSLP_DIR_PUSH_PULL && dat1_reg[k])))
            else $error("gpio drive");
    end
    chk_blink_off: assert property (
        $rose(pin_oe_o[1]) && off_reg > 2 |-> off_reg == BLINK_TICKS * 10) else $error("blink");
    chk_blink_bound: assert property (
        off_reg <= BLINK_TICKS * 10) else $error("blink long");
    chk_swap_gate: assert property (
        $stable(auto_crossover_en_o) |-> line_pairs_swapped_o
        == (auto_crossover_en_o && $past(crossover_pair_swap_i))) else $error("swap");
endmodule
`default_nettype wire

/* sim/gslp_board.sv */
// board side: pad pull-ups, lamps and crossover strap
`timescale 1ns/10ps
`default_nettype none
module gslp_board (
    input  wire logic [2:0] drive_i,
    input  wire logic [2:0] drive_en_i,
    input  wire logic [2:0] ext_en_i,
    input  wire logic [2:0] ext_val_i,
    input  wire logic       strap_gnd_i,
    output logic [2:0]      pad_o,
    output logic            strap_o
);
    // lamps hang from the supply, so a released pad floats high
    assign pad_o = (drive_en_i & drive_i) | (~drive_en_i & (~ext_en_i | ext_val_i));
    // open strap reads high through its pull-up
    assign strap_o = !strap_gnd_i;
endmodule
`default_nettype wire

/* sim/gslp_pins_tb.sv */
// self-checking bench for the gpio and status lamp pin block
`timescale 1ns/10ps
`default_nettype none
module gslp_pins_tb;
    localparam int unsigned BT = 5;
    logic                       sys_clk_i = '0, rst_b_i = '0, swap = '0, gnd = '0;
    logic                       strap, xen, swapped, tick;
    logic [2:0]                 dat = '0, mode = '0, ext_en = '0, pad, drv, drv_en, pin_in;
    gslp_pkg::gslp_dir_t [2:0]  dir = '0;
    gslp_pkg::gslp_phy_status_s st = '0;
    int                         miscompares = 0, num_checks = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    gslp_pins #(.BLINK_TICKS(BT)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .pin_dir_i(dir), .pin_out_data_i(dat), .pin_lamp_mode_i(mode), .phy_status_i(st),
        .pin_i(pad), .auto_crossover_strap_i(strap), .crossover_pair_swap_i(swap), .pin_o(drv),
        .pin_oe_o(drv_en), .pin_in_data_o(pin_in), .auto_crossover_en_o(xen),
        .line_pairs_swapped_o(swapped), .ref_tick_o(tick));
    gslp_board board (.drive_i(drv), .drive_en_i(drv_en), .ext_en_i(ext_en),
        .ext_val_i(3'h6), .strap_gnd_i(gnd), .pad_o(pad), .strap_o(strap));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (pad[1] === lvl && n < 1000) begin
            cyc(1);
            n++;
        end
        if (n >= 1000) begin
            miscompares++;
            print_verdict;
        end
    endtask
    task automatic t_strap(input logic g);
        gnd = g;
        rst_b_i = '0;
        cyc(10);
        rst_b_i = 1'h1;
        swap = 1'h1;
        cyc(8);
        cmp("xover_en", !g, xen);
        cmp("swapped", !g, swapped);
        swap = '0;
    endtask
    task automatic t_gpio;
        for (int d = 0; d < 4; d++) begin
            dir = {3{2'(d)}};
            dat = 3'h5;
            // outside drive only where the pin listens, to avoid contention
            ext_en = (d == 0 || d == 3) ? 3'h7 : 3'h0;
            cyc(5);
            cmp("pad", (d == 1 || d == 2) ? 3'h5 : 3'h6, pad);
            cmp("in_data", (d == 1 || d == 2) ? 3'h5 : 3'h6, pin_in);
        end
    endtask
    task automatic t_tick;
        int n;
        n = 0;
        repeat (100) begin
            cyc(1);
            n += (tick === 1'h1);
        end
        cmp("ticks", 10, n);
    endtask
    task automatic t_lamps;
        logic [4:0] v [5] = '{5'h00, 5'h16, 5'h1C, 5'h02, 5'h04};
        logic [2:0] e [5] = '{3'h6, 3'h1, 3'h4, 3'h6, 3'h4};
        ext_en = '0;
        dir = {3{2'h1}};
        dat = 3'h7;
        mode = 3'h7;
        for (int i = 0; i < 5; i++) begin
            st = v[i];
            cyc(4);
            cmp("lamps", e[i], pad);
        end
    endtask
    task automatic t_blink;
        int n;
        st = 5'h05;
        run_len(1'h0, n);
        run_len(1'h1, n);
        cmp("off_time", BT * 10, n);
        run_len(1'h0, n);
        cmp("relit_min", 1, n >= BT * 10);
        run_len(1'h1, n);
        cmp("off_again", BT * 10, n);
    endtask
    initial begin
        t_strap(1'h0);
        t_strap(1'h1);
        t_gpio;
        t_tick;
        t_lamps;
        t_blink;
        print_verdict;
    end
endmodule
bind gslp_pins gslp_pins_props #(.BLINK_TICKS(BLINK_TICKS)) u_props (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .pin_dir_i(pin_dir_i), .pin_out_data_i(pin_out_data_i),
    .pin_lamp_mode_i(pin_lamp_mode_i), .phy_status_i(phy_status_i),
    .crossover_pair_swap_i(crossover_pair_swap_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .auto_crossover_en_o(auto_crossover_en_o), .line_pairs_swapped_o(line_pairs_swapped_o),
    .ref_tick_o(ref_tick_o));
`default_nettype wire
